/* File: core/scg_defines.svh */
// register offsets, reset values and field positions of the clock gate block
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH

`define SCG_ADDR_W 8
`define SCG_DATA_W 32

`define SCG_OFF_AWAKE_LO 8'ha0
`define SCG_OFF_AWAKE_HI 8'ha4
`define SCG_OFF_SLEEP_LO 8'ha8
`define SCG_OFF_SLEEP_HI 8'hac
`define SCG_OFF_ACTIVE_LO 8'hb0
`define SCG_OFF_ACTIVE_HI 8'hb4
`define SCG_OFF_IRQ_RAW 8'hb8
`define SCG_OFF_IRQ_MASK 8'hbc
`define SCG_OFF_IRQ_FORCE 8'hc0
`define SCG_OFF_IRQ_STATUS 8'hc4

`define SCG_LO_W 32
`define SCG_HI_W 15
`define SCG_GATE_W 47

`define SCG_GATE_LO_RST 32'hffffffff
`define SCG_GATE_HI_RST 15'h7fff
`define SCG_ACTIVE_RST 47'h0
`define SCG_IRQ_BIT_RST 1'h0

`define SCG_IRQ_BIT 0

`endif

/* File: core/scg_pkg.sv */
// types of the clock gate block
package scg_pkg;

   // phase of an apb access
   typedef enum logic [1:0] {
      SCG_APB_WAIT = 2'b01,
      SCG_APB_DONE = 2'b10
   } scg_apb_st_t;

endpackage

/* File: core/scg_gate_bank.sv */
// per-consumer selection of the running clock enable
`timescale 1ns/1ns
`include "scg_defines.svh"

module scg_gate_bank #(
   parameter int WIDTH = `SCG_GATE_W
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // mode and enables
   input wire logic chip_asleep,
   input wire logic [WIDTH-1:0] awake_gates,
   input wire logic [WIDTH-1:0] sleep_gates,
   // current enables
   output logic [WIDTH-1:0] active_reg
);

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk_sys) begin
            if (reset) begin
               active_reg[i] <= 1'b0; // see R2
            end else if (chip_asleep) begin
               active_reg[i] <= sleep_gates[i]; // see R8
            end else begin
               active_reg[i] <= awake_gates[i]; // see R8
            end
         end
      end
   endgenerate

endmodule

/* File: core/scg_irq.sv */
// recovery interrupt: raw sticky bit, enable, force and status
`timescale 1ns/1ns
`include "scg_defines.svh"

module scg_irq (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // event and software controls
   input wire logic recovery_event,
   input wire logic raw_clear,
   input wire logic mask_bit,
   input wire logic force_bit,
   // state
   output logic raw_reg,
   output logic status,
   output logic irq_reg
);

   logic irq_next;

   // sticky; a new event beats a clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         raw_reg <= `SCG_IRQ_BIT_RST; // see R3
      end else if (recovery_event) begin
         raw_reg <= 1'b1; // see R3
      end else if (raw_clear) begin
         raw_reg <= 1'b0;
      end
   end

   assign status = (raw_reg & mask_bit) | force_bit; // see R6
   assign irq_next = status;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next; // see R5
      end
   end

endmodule

/* File: core/scg_top.sv */
// clock gate control with apb registers and recovery interrupt
// Function
// R1 - sleep enable bit per consumer, resets one
// R2 - read-only current enable bits, reset zero
// R3 - raw recovery event in bit zero
// R4 - interrupt enable bit zero, resets zero
// R5 - force bit asserts interrupt regardless
// R6 - status is raw and enable, or force
// R7 - awake enable registers, same layout, reset one
// R8 - current enable follows awake or sleep set
`timescale 1ns/1ns
`include "scg_defines.svh"

module scg_top (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`SCG_ADDR_W-1:0] paddr,
   input wire logic [`SCG_DATA_W-1:0] pwdata,
   output logic [`SCG_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // chip power state and events
   input wire logic chip_asleep,
   input wire logic system_clock_recovery_event,
   // gated clock enables to consumers
   output logic [`SCG_GATE_W-1:0] gate_enable,
   // interrupt
   output logic irq
);

   scg_pkg::scg_apb_st_t apb_st_reg;
   scg_pkg::scg_apb_st_t apb_st_next;
   logic [`SCG_LO_W-1:0] awake_gate_lower_reg;
   logic [`SCG_HI_W-1:0] awake_gate_upper_reg;
   logic [`SCG_LO_W-1:0] sleep_gate_lower_reg;
   logic [`SCG_HI_W-1:0] sleep_gate_upper_reg;
   logic irq_mask_reg;
   logic irq_force_reg;
   logic irq_raw;
   logic irq_status;
   logic irq_line;
   logic [`SCG_GATE_W-1:0] active_gates;
   logic [`SCG_DATA_W-1:0] rd_data;
   logic rd_hit;
   logic access;
   logic wr_fire;
   logic raw_clear;

   // access phase: first cycle prepares answer, second completes
   assign access = psel & penable;
   assign wr_fire = access & pwrite & (apb_st_reg == scg_pkg::SCG_APB_DONE);

   always_comb begin
      apb_st_next = apb_st_reg;
      case (apb_st_reg)
         scg_pkg::SCG_APB_WAIT: begin
            if (access) begin
               apb_st_next = scg_pkg::SCG_APB_DONE;
            end
         end
         scg_pkg::SCG_APB_DONE: begin
            apb_st_next = scg_pkg::SCG_APB_WAIT;
         end
         default: begin
            apb_st_next = scg_pkg::SCG_APB_WAIT;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         apb_st_reg <= scg_pkg::SCG_APB_WAIT;
      end else begin
         apb_st_reg <= apb_st_next;
      end
   end

   // read decode
   always_comb begin
      rd_data = '0;
      rd_hit = 1'b1;
      case (paddr)
         `SCG_OFF_AWAKE_LO: begin
            rd_data = awake_gate_lower_reg;
         end
         `SCG_OFF_AWAKE_HI: begin
            rd_data = {17'h0, awake_gate_upper_reg};
         end
         `SCG_OFF_SLEEP_LO: begin
            rd_data = sleep_gate_lower_reg;
         end
         `SCG_OFF_SLEEP_HI: begin
            rd_data = {17'h0, sleep_gate_upper_reg};
         end
         `SCG_OFF_ACTIVE_LO: begin
            rd_data = active_gates[`SCG_LO_W-1:0]; // see R2
         end
         `SCG_OFF_ACTIVE_HI: begin
            rd_data = {17'h0, active_gates[`SCG_GATE_W-1:`SCG_LO_W]};
         end
         `SCG_OFF_IRQ_RAW: begin
            rd_data[`SCG_IRQ_BIT] = irq_raw; // see R3
         end
         `SCG_OFF_IRQ_MASK: begin
            rd_data[`SCG_IRQ_BIT] = irq_mask_reg;
         end
         `SCG_OFF_IRQ_FORCE: begin
            rd_data[`SCG_IRQ_BIT] = irq_force_reg;
         end
         `SCG_OFF_IRQ_STATUS: begin
            rd_data[`SCG_IRQ_BIT] = irq_status; // see R6
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // answer registered on the first access cycle
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (access & (apb_st_reg == scg_pkg::SCG_APB_WAIT)) begin
         pready <= 1'b1;
         prdata <= pwrite ? '0 : rd_data;
         pslverr <= ~rd_hit;
      end else begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end
   end

   // awake gate registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         awake_gate_lower_reg <= `SCG_GATE_LO_RST; // see R7
         awake_gate_upper_reg <= `SCG_GATE_HI_RST; // see R7
      end else if (wr_fire) begin
         if (paddr == `SCG_OFF_AWAKE_LO) begin
            awake_gate_lower_reg <= pwdata; // see R7
         end
         if (paddr == `SCG_OFF_AWAKE_HI) begin
            awake_gate_upper_reg <= pwdata[`SCG_HI_W-1:0]; // see R7
         end
      end
   end

   // sleep gate registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sleep_gate_lower_reg <= `SCG_GATE_LO_RST; // see R1
         sleep_gate_upper_reg <= `SCG_GATE_HI_RST; // see R1
      end else if (wr_fire) begin
         if (paddr == `SCG_OFF_SLEEP_LO) begin
            sleep_gate_lower_reg <= pwdata; // see R1
         end
         if (paddr == `SCG_OFF_SLEEP_HI) begin
            sleep_gate_upper_reg <= pwdata[`SCG_HI_W-1:0]; // see R1
         end
      end
   end

   // interrupt enable and force
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq_mask_reg <= `SCG_IRQ_BIT_RST; // see R4
         irq_force_reg <= `SCG_IRQ_BIT_RST; // see R5
      end else if (wr_fire) begin
         if (paddr == `SCG_OFF_IRQ_MASK) begin
            irq_mask_reg <= pwdata[`SCG_IRQ_BIT]; // see R4
         end
         if (paddr == `SCG_OFF_IRQ_FORCE) begin
            irq_force_reg <= pwdata[`SCG_IRQ_BIT]; // see R5
         end
      end
   end

   // write one to raw bit clears it
   assign raw_clear = wr_fire & (paddr == `SCG_OFF_IRQ_RAW) &
                      pwdata[`SCG_IRQ_BIT];

   scg_irq u_irq (
      .clk_sys(clk_sys),
      .reset(reset),
      .recovery_event(system_clock_recovery_event),
      .raw_clear(raw_clear),
      .mask_bit(irq_mask_reg),
      .force_bit(irq_force_reg),
      .raw_reg(irq_raw),
      .status(irq_status),
      .irq_reg(irq_line)
   );

   scg_gate_bank #(
      .WIDTH(`SCG_GATE_W)
   ) u_bank (
      .clk_sys(clk_sys),
      .reset(reset),
      .chip_asleep(chip_asleep),
      .awake_gates({awake_gate_upper_reg, awake_gate_lower_reg}),
      .sleep_gates({sleep_gate_upper_reg, sleep_gate_lower_reg}),
      .active_reg(active_gates)
   );

   assign gate_enable = active_gates; // see R8
   assign irq = irq_line;

endmodule

/* File: sim/scg_checker_assertions.sv */
// port assertions for the clock gate block
`timescale 1ns/1ns
module scg_checker (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // apb
   input wire logic psel,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   // state and outputs
   input wire logic chip_asleep,
   input wire logic system_clock_recovery_event,
   input wire logic [46:0] gate_enable,
   input wire logic irq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   property p_gate_rst; $fell(reset) |=> &gate_enable; endproperty
   a_gate_rst: assert property (p_gate_rst) else $error("gate reset");
   property p_hold;
      !$past(reset) && !(psel && pwrite) && !$past(psel && pwrite)
         && $stable(chip_asleep) |=> $stable(gate_enable);
   endproperty
   a_hold: assert property (p_hold) else $error("gate moved");
   property p_act_lo;
      pready && !pwrite && paddr == 8'hb0 |-> prdata == $past(gate_enable[31:0]);
   endproperty
   a_act_lo: assert property (p_act_lo) else $error("active lo");
   property p_act_hi;
      pready && !pwrite && paddr == 8'hb4
         |-> prdata == {17'h0, $past(gate_enable[46:32])};
   endproperty
   a_act_hi: assert property (p_act_hi) else $error("active hi");
   property p_raw;
      pready && !pwrite && paddr == 8'hb8
         && $past(system_clock_recovery_event, 2) |-> prdata[0];
   endproperty
   a_raw: assert property (p_raw) else $error("raw lost");
   property p_force;
      pready && pwrite && paddr == 8'hc0 && pwdata[0] |-> ##2 irq;
   endproperty
   a_force: assert property (p_force) else $error("force");
   property p_stat;
      pready && !pwrite && paddr == 8'hc4 |-> prdata[0] == irq;
   endproperty
   a_stat: assert property (p_stat) else $error("status");
   property p_rsvd;
      pready && !pwrite && paddr >= 8'hb8 && paddr <= 8'hc4
         |-> prdata[31:1] == 31'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved");
endmodule
bind scg_top scg_checker chk (.clk_sys(clk_sys), .reset(reset),
   .psel(psel), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .chip_asleep(chip_asleep),
   .system_clock_recovery_event(system_clock_recovery_event),
   .gate_enable(gate_enable), .irq(irq));

/* File: sim/scg_far_side.sv */
// sleep control and recovery event source
`timescale 1ns/1ns
module scg_far_side (
   // clock
   input wire logic clk_sys,
   // requests
   input wire logic sleep_req,
   input wire logic fault_req,
   // to the block
   output logic chip_asleep,
   output logic system_clock_recovery_event
);
   always @(posedge clk_sys) begin
      chip_asleep <= sleep_req;
      system_clock_recovery_event <= fault_req;
   end
endmodule

/* File: sim/tb.sv */
// testbench for the clock gate block
`timescale 1ns/1ns
module tb;
   logic clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, asleep, evt, irq;
   logic sleep_req = 0, fault_req = 0;
   logic [46:0] gate_enable;
   int num_errors = 0, comparisons = 0;
   always #20 clk_sys = ~clk_sys;
   scg_top uut (.clk_sys(clk_sys), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chip_asleep(asleep), .system_clock_recovery_event(evt),
      .gate_enable(gate_enable), .irq(irq));
   scg_far_side far (.clk_sys(clk_sys), .sleep_req(sleep_req),
      .fault_req(fault_req), .chip_asleep(asleep),
      .system_clock_recovery_event(evt));
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata; er = pslverr; psel <= 0; penable <= 0;
   endtask
   task automatic chk(input logic [46:0] got, input logic [46:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(0, a, 32'h0); chk(rd, e);
   endtask
   task automatic wt; repeat (3) @(posedge clk_sys); endtask
   task automatic t_reset;
      for (int i = 0; i < 10; i++)
         rdc(8'ha0 + 8'(4 * i), i > 5 ? 32'h0 : i[0] ? 32'h7fff : '1);
      chk(gate_enable, '1);
      $display("reset values done");
   endtask
   task automatic t_gate;
      bus(1, 8'ha0, 32'hf0); bus(1, 8'ha8, 32'h0f); bus(1, 8'hac, 32'h1);
      wt; chk(gate_enable, {15'h7fff, 32'hf0});
      sleep_req <= 1; wt; chk(gate_enable, {15'h1, 32'hf});
      bus(1, 8'hb0, '1); rdc(8'hb0, 32'hf); rdc(8'hb4, 32'h1);
      sleep_req <= 0; wt; rdc(8'hb0, 32'hf0);
      $display("gating done");
   endtask
   task automatic t_irq;
      fault_req <= 1; rdc(8'hb8, 32'h1); fault_req <= 0; wt;
      chk(irq, 0); rdc(8'hc4, 32'h0);
      bus(1, 8'hbc, 32'h1); wt; chk(irq, 1); rdc(8'hc4, 32'h1);
      bus(1, 8'hb8, 32'h1); wt; chk(irq, 0);
      bus(1, 8'hbc, 32'h0); bus(1, 8'hc0, 32'h1); wt; chk(irq, 1);
      bus(1, 8'hc0, 32'h0); wt; chk(irq, 0);
      bus(0, 8'h04, 32'h0); chk(er, 1); chk(rd, 0);
      $display("interrupt done");
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      reset <= 0;
      t_reset;
      t_gate;
      t_irq;
      close_out;
   end
   initial begin
      #200000;
      num_errors++;
      close_out;
   end
endmodule
